// File: hdl/tdd_pkg.sv
// package: constants and carrier type of the three-dimensional dma engine
package tdd_pkg;
    // ****************************************
    // parameter memory layout
    // ****************************************
    localparam logic [31:0] PRM_BASE_ABS = 32'h02a0_4000;
    localparam logic [15:0] PRM_OFS      = 16'h4000;
    localparam logic [15:0] PRM_END      = 16'h5fff;
    localparam int          SET_CNT      = 256;
    localparam int          SET_WORDS    = 8;
    localparam logic [2:0]  W_OPT        = 3'h0;
    localparam logic [2:0]  W_SRC        = 3'h1;
    localparam logic [2:0]  W_CNT_AB     = 3'h2;
    localparam logic [2:0]  W_DST        = 3'h3;
    localparam logic [2:0]  W_BIDX       = 3'h4;
    localparam logic [2:0]  W_LINK       = 3'h5;
    localparam logic [2:0]  W_CIDX       = 3'h6;
    localparam logic [2:0]  W_FRAMES_PER_BLOCK       = 3'h7;
    localparam int          OPT_SYNC_BIT = 2;
    localparam int          OPT_TCC_LSB  = 12;
    localparam logic [15:0] NULL_LINK    = 16'hffff;
    localparam int          LINK_SET_LSB = 5;
    // ****************************************
    // control registers
    // ****************************************
    localparam logic [15:0] REG_TRIG     = 16'h0000;
    localparam logic [15:0] REG_STAT     = 16'h0004;
    localparam logic [7:0]  REG_MAP_PG   = 8'h01;
    localparam logic [7:0]  RST_MAP      = 8'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    // ****************************************
    // transfer request carrier
    // ****************************************
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] array_byte_count;
        logic [15:0] arrays_per_frame;
        logic [15:0] sbidx;
        logic [15:0] dbidx;
        logic [5:0]  tcc;
    } tdd_tr_t;
endpackage

// File: hdl/tdd_dma_top.sv
// module: channel side, transfer side and register slave of the dma engine
// Overview of operation
// - idle engine puts first request in program set, then straight to active and queue
// - a second request is held in the program set while one is active
// - when source context ends, program set moves to active set and queue entry
// - a read is issued only if the data fifo has room for its byte
// - writes start only once read data sits in the data fifo
// - reads run ahead of writes by at most the queue depth, two or four
// - a finished transfer returns its completion code
// - each transfer has arrays of bytes, arrays per frame and frames per block
// - array start is previous array start plus the array stride
// - one option bit selects array or frame synchronised mode
// - array mode sends one array per trigger, arrays times frames triggers in all
// - array mode frame end adds frame stride to last array start
// - frame mode sends one frame per trigger, frames_per_block triggers in all
// - frame mode adds frame stride to the frame's first array start
// - parameter memory holds 256 sets of eight 32-bit words
// - set n sits at base plus 32 times n
// - any set serves as channel or reload link set
// - every channel maps to set 0 after reset
// - a request carries addresses, counts, strides and options
// - array mode reloads arrays_per_frame from frame_count_reload
// - a link of all ones is null, nothing is copied
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module tdd_dma_top #(
    parameter int NUM_CH     = 4,
    parameter int DQ_N       = 2,
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             rd_req_o,
    output logic      [31:0] rd_addr_o,
    input  wire logic        rd_gnt_i,
    input  wire logic        rd_valid_i,
    input  wire logic [7:0]  rd_data_i,
    output logic             wr_req_o,
    output logic      [31:0] wr_addr_o,
    output logic      [7:0]  wr_data_o,
    input  wire logic        wr_gnt_i,
    output logic             cmpl_o,
    output logic      [5:0]  cmpl_code_o
);
    localparam int FA = $clog2(FIFO_DEPTH);
    localparam int QA = $clog2(DQ_N);
    localparam int CA = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // ****************************************
    // register slave
    // ****************************************
    logic [31:0] prm_mem [tdd_pkg::SET_CNT*tdd_pkg::SET_WORDS];
    logic [7:0]  chmap_r [NUM_CH];
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [NUM_CH-1:0] pend_r;

    wire         bus_req  = avs_read_i | avs_write_i;
    wire         bus_we   = avs_write_i & ack_r;
    wire [15:0]  prm_rel  = avs_address_i - tdd_pkg::PRM_OFS;
    wire [10:0]  prm_idx  = prm_rel[12:2];
    wire         is_prm   = (avs_address_i >= tdd_pkg::PRM_OFS) &&
                            (avs_address_i <= tdd_pkg::PRM_END);
    wire         is_trig  = avs_address_i == tdd_pkg::REG_TRIG;
    wire         is_stat  = avs_address_i == tdd_pkg::REG_STAT;
    wire         is_map   = (avs_address_i[15:8] == tdd_pkg::REG_MAP_PG) &&
                            (32'(avs_address_i[7:2]) < NUM_CH);
    wire [CA-1:0] map_ch  = CA'(avs_address_i[7:2]);

    // one wait cycle, then the answer; unmapped reads give zero
    assign avs_waitrequest_o = bus_req & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    logic prog_vld_r;
    logic sa_vld_r;
    logic wb_vld_r;
    logic [QA:0] dq_cnt_r;
    wire [31:0] stat_w = {16'h0000, 8'(pend_r), 1'b0, 3'(dq_cnt_r),
                          1'b0, wb_vld_r, sa_vld_r, prog_vld_r};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r   <= 1'b0;
            rdata_r <= tdd_pkg::RST_WORD;
        end else begin
            ack_r   <= bus_req & ~ack_r;
            rdata_r <= is_prm  ? prm_mem[prm_idx] :
                       is_stat ? stat_w :
                       is_map  ? {24'h000000, chmap_r[map_ch]} : tdd_pkg::RST_WORD;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < NUM_CH; c++) begin
                chmap_r[c] <= tdd_pkg::RST_MAP;
            end
        end else if (bus_we && is_map) begin
            chmap_r[map_ch] <= avs_writedata_i[7:0];
        end
    end

    // ****************************************
    // channel side: trigger pick and set update
    // ****************************************
    logic [CA-1:0] sel_ch;
    logic          sel_any;
    always_comb begin
        sel_ch  = '0;
        sel_any = 1'b0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (pend_r[c]) begin
                sel_ch  = CA'(c);
                sel_any = 1'b1;
            end
        end
    end

    wire [7:0]  cur_set = chmap_r[sel_ch];
    logic [31:0] cw [tdd_pkg::SET_WORDS];
    always_comb begin
        for (int k = 0; k < tdd_pkg::SET_WORDS; k++) begin
            cw[k] = prm_mem[{cur_set, 3'(k)}];
        end
    end

    wire [31:0] channel_options     = cw[tdd_pkg::W_OPT];
    wire [31:0] src     = cw[tdd_pkg::W_SRC];
    wire [15:0] array_byte_count    = cw[tdd_pkg::W_CNT_AB][15:0];
    wire [15:0] arrays_per_frame    = cw[tdd_pkg::W_CNT_AB][31:16];
    wire [31:0] dst     = cw[tdd_pkg::W_DST];
    wire [15:0] sbidx   = cw[tdd_pkg::W_BIDX][15:0];
    wire [15:0] dbidx   = cw[tdd_pkg::W_BIDX][31:16];
    wire [15:0] link    = cw[tdd_pkg::W_LINK][15:0];
    wire [15:0] brld    = cw[tdd_pkg::W_LINK][31:16];
    wire [15:0] scidx   = cw[tdd_pkg::W_CIDX][15:0];
    wire [15:0] dcidx   = cw[tdd_pkg::W_CIDX][31:16];
    wire [15:0] frames_per_block    = cw[tdd_pkg::W_FRAMES_PER_BLOCK][15:0];
    wire        sync_ab = channel_options[tdd_pkg::OPT_SYNC_BIT];
    wire [7:0]  lnk_set = link[tdd_pkg::LINK_SET_LSB +: 8];
    wire        lnk_ok  = link != tdd_pkg::NULL_LINK;

    // a set with any zero count is null: its trigger is dropped, no request
    wire set_null = (array_byte_count == 16'h0000) || (arrays_per_frame == 16'h0000) || (frames_per_block == 16'h0000);
    wire tr_go    = sel_any & ~prog_vld_r & ~set_null;
    wire serve    = sel_any & (~prog_vld_r | set_null);
    wire a_inner  = ~sync_ab && (arrays_per_frame > 16'h0001);
    wire set_last = (sync_ab || arrays_per_frame == 16'h0001) && frames_per_block == 16'h0001;

    wire [31:0] nx_src  = src + (a_inner ? {{16{sbidx[15]}}, sbidx}
                                         : {{16{scidx[15]}}, scidx});
    wire [31:0] nx_dst  = dst + (a_inner ? {{16{dbidx[15]}}, dbidx}
                                         : {{16{dcidx[15]}}, dcidx});
    wire [15:0] nx_arrays_per_frame = a_inner ? arrays_per_frame - 16'h0001 : (sync_ab ? arrays_per_frame : brld);
    wire [15:0] nx_frames_per_block = a_inner ? frames_per_block : frames_per_block - 16'h0001;

    tdd_pkg::tdd_tr_t tr_w;
    assign tr_w = '{src: src, dst: dst, array_byte_count: array_byte_count,
                    arrays_per_frame: sync_ab ? arrays_per_frame : 16'h0001,
                    sbidx: sbidx, dbidx: dbidx,
                    tcc: channel_options[tdd_pkg::OPT_TCC_LSB +: 6]};

    always_ff @(posedge ref_clk_i) begin
        if (bus_we && is_prm) begin
            for (int b = 0; b < 4; b++) begin
                if (avs_byteenable_i[b]) begin
                    prm_mem[prm_idx][8*b +: 8] <= avs_writedata_i[8*b +: 8];
                end
            end
        end
        if (tr_go && set_last && lnk_ok) begin
            for (int k = 0; k < tdd_pkg::SET_WORDS; k++) begin
                prm_mem[{cur_set, 3'(k)}] <= prm_mem[{lnk_set, 3'(k)}];
            end
        end else if (tr_go && set_last) begin
            prm_mem[{cur_set, tdd_pkg::W_FRAMES_PER_BLOCK}] <= tdd_pkg::RST_WORD;
        end else if (tr_go) begin
            prm_mem[{cur_set, tdd_pkg::W_SRC}]    <= nx_src;
            prm_mem[{cur_set, tdd_pkg::W_DST}]    <= nx_dst;
            prm_mem[{cur_set, tdd_pkg::W_CNT_AB}] <= {nx_arrays_per_frame, array_byte_count};
            prm_mem[{cur_set, tdd_pkg::W_FRAMES_PER_BLOCK}]   <= {16'h0000, nx_frames_per_block};
        end
    end

    // a trigger written in the cycle its flag clears is kept
    wire [NUM_CH-1:0] trig_set = (bus_we && is_trig) ? avs_writedata_i[NUM_CH-1:0] : '0;
    wire [NUM_CH-1:0] trig_clr = serve ? NUM_CH'(1) << sel_ch : '0;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_r <= '0;
        end else begin
            pend_r <= (pend_r & ~trig_clr) | trig_set;
        end
    end

    // ****************************************
    // transfer side: program set, active set, queue
    // ****************************************
    tdd_pkg::tdd_tr_t prog_r;
    tdd_pkg::tdd_tr_t dq_mem [DQ_N];
    logic [QA-1:0] dq_wp_r;
    logic [QA-1:0] dq_rp_r;
    wire  mv = prog_vld_r & ~sa_vld_r & (32'(dq_cnt_r) < DQ_N);

    logic [31:0] sa_base_r;
    logic [31:0] sa_addr_r;
    logic [15:0] sa_off_r;
    logic [15:0] sa_arr_r;
    logic [15:0] sa_array_byte_count_r;
    logic [15:0] sa_bidx_r;
    logic [FA:0] fifo_cnt_r;
    logic [FA:0] rd_out_r;
    logic [7:0]  fifo_mem [FIFO_DEPTH];
    logic [FA-1:0] fifo_wp_r;
    logic [FA-1:0] fifo_rp_r;

    wire space_ok = 32'(fifo_cnt_r) + 32'(rd_out_r) < FIFO_DEPTH;
    assign rd_req_o  = sa_vld_r & space_ok;
    assign rd_addr_o = sa_addr_r;
    wire rd_fire   = rd_req_o & rd_gnt_i;
    wire sa_arr_end = sa_off_r == sa_array_byte_count_r - 16'h0001;
    wire [31:0] sa_next = sa_base_r + {{16{sa_bidx_r[15]}}, sa_bidx_r};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_vld_r <= 1'b0;
            prog_r     <= '0;
        end else if (tr_go) begin
            prog_vld_r <= 1'b1;
            prog_r     <= tr_w;
        end else if (mv) begin
            prog_vld_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sa_vld_r  <= 1'b0;
            sa_base_r <= '0;
            sa_addr_r <= '0;
            sa_off_r  <= '0;
            sa_arr_r  <= '0;
            sa_array_byte_count_r <= '0;
            sa_bidx_r <= '0;
        end else if (mv) begin
            sa_vld_r  <= 1'b1;
            sa_base_r <= prog_r.src;
            sa_addr_r <= prog_r.src;
            sa_off_r  <= '0;
            sa_arr_r  <= prog_r.arrays_per_frame;
            sa_array_byte_count_r <= prog_r.array_byte_count;
            sa_bidx_r <= prog_r.sbidx;
        end else if (rd_fire && sa_arr_end) begin
            sa_vld_r  <= sa_arr_r != 16'h0001;
            sa_base_r <= sa_next;
            sa_addr_r <= sa_next;
            sa_off_r  <= '0;
            sa_arr_r  <= sa_arr_r - 16'h0001;
        end else if (rd_fire) begin
            sa_addr_r <= sa_addr_r + 32'h0000_0001;
            sa_off_r  <= sa_off_r + 16'h0001;
        end
    end

    // ****************************************
    // write side and data fifo
    // ****************************************
    logic [31:0] wb_base_r;
    logic [31:0] wb_addr_r;
    logic [15:0] wb_off_r;
    logic [15:0] wb_arr_r;
    logic [15:0] wb_array_byte_count_r;
    logic [15:0] wb_bidx_r;
    logic [5:0]  wb_tcc_r;
    logic        cmpl_r;
    logic [5:0]  cmpl_code_r;

    assign wr_req_o  = wb_vld_r & (fifo_cnt_r != '0);
    assign wr_addr_o = wb_addr_r;
    assign wr_data_o = fifo_mem[fifo_rp_r];
    assign cmpl_o      = cmpl_r;
    assign cmpl_code_o = cmpl_code_r;
    wire wr_fire    = wr_req_o & wr_gnt_i;
    wire wb_arr_end = wb_off_r == wb_array_byte_count_r - 16'h0001;
    wire wb_done    = wr_fire & wb_arr_end & (wb_arr_r == 16'h0001);
    wire wb_start   = ~wb_vld_r & (dq_cnt_r != '0);
    wire [31:0] wb_next = wb_base_r + {{16{wb_bidx_r[15]}}, wb_bidx_r};

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_vld_r  <= 1'b0;
            wb_base_r <= '0;
            wb_addr_r <= '0;
            wb_off_r  <= '0;
            wb_arr_r  <= '0;
            wb_array_byte_count_r <= '0;
            wb_bidx_r <= '0;
            wb_tcc_r  <= '0;
        end else if (wb_start) begin
            wb_vld_r  <= 1'b1;
            wb_base_r <= dq_mem[dq_rp_r].dst;
            wb_addr_r <= dq_mem[dq_rp_r].dst;
            wb_off_r  <= '0;
            wb_arr_r  <= dq_mem[dq_rp_r].arrays_per_frame;
            wb_array_byte_count_r <= dq_mem[dq_rp_r].array_byte_count;
            wb_bidx_r <= dq_mem[dq_rp_r].dbidx;
            wb_tcc_r  <= dq_mem[dq_rp_r].tcc;
        end else if (wr_fire && wb_arr_end) begin
            wb_vld_r  <= wb_arr_r != 16'h0001;
            wb_base_r <= wb_next;
            wb_addr_r <= wb_next;
            wb_off_r  <= '0;
            wb_arr_r  <= wb_arr_r - 16'h0001;
        end else if (wr_fire) begin
            wb_addr_r <= wb_addr_r + 32'h0000_0001;
            wb_off_r  <= wb_off_r + 16'h0001;
        end
    end

    // queue entry stays counted until its last byte is written
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_wp_r  <= '0;
            dq_rp_r  <= '0;
            dq_cnt_r <= '0;
            cmpl_r   <= 1'b0;
            cmpl_code_r <= '0;
        end else begin
            dq_wp_r  <= dq_wp_r + QA'(mv);
            dq_rp_r  <= dq_rp_r + QA'(wb_done);
            dq_cnt_r <= dq_cnt_r + (QA+1)'(mv) - (QA+1)'(wb_done);
            cmpl_r   <= wb_done;
            cmpl_code_r <= wb_done ? wb_tcc_r : cmpl_code_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (mv) begin
            dq_mem[dq_wp_r] <= prog_r;
        end
        if (rd_valid_i) begin
            fifo_mem[fifo_wp_r] <= rd_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fifo_wp_r  <= '0;
            fifo_rp_r  <= '0;
            fifo_cnt_r <= '0;
            rd_out_r   <= '0;
        end else begin
            fifo_wp_r  <= fifo_wp_r + FA'(rd_valid_i);
            fifo_rp_r  <= fifo_rp_r + FA'(wr_fire);
            fifo_cnt_r <= fifo_cnt_r + (FA+1)'(rd_valid_i) - (FA+1)'(wr_fire);
            rd_out_r   <= rd_out_r + (FA+1)'(rd_fire) - (FA+1)'(rd_valid_i);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    prog_to_active_a: assert property (mv |=> sa_vld_r && !prog_vld_r)
        else $error("program set did not move to active set");
    prog_hold_a: assert property (tr_go |=> prog_vld_r && prog_r.src == $past(src))
        else $error("request not held in program set");
    queue_load_a: assert property (mv |=> dq_cnt_r == $past(dq_cnt_r) + 1 - $past(wb_done))
        else $error("queue entry not loaded with active set");
    read_space_a: assert property (32'(fifo_cnt_r) + 32'(rd_out_r) <= FIFO_DEPTH)
        else $error("read issued without fifo space");
    write_data_a: assert property (wr_req_o |-> fifo_cnt_r != '0)
        else $error("write issued with empty fifo");
    run_ahead_a: assert property (32'(dq_cnt_r) <= DQ_N)
        else $error("read side ran too far ahead");
    done_code_a: assert property (wb_done |=> cmpl_o && cmpl_code_o == $past(wb_tcc_r))
        else $error("completion code missing");
    array_one_a: assert property (tr_go && !sync_ab |-> tr_w.arrays_per_frame == 16'h0001)
        else $error("array mode request not one array");
    frame_whole_a: assert property (tr_go && sync_ab |-> tr_w.arrays_per_frame == arrays_per_frame)
        else $error("frame mode request not whole frame");
    null_link_a: assert property (tr_go && set_last && !lnk_ok
        |=> prm_mem[{$past(cur_set), tdd_pkg::W_FRAMES_PER_BLOCK}] == tdd_pkg::RST_WORD)
        else $error("null link did not empty the set");

    array_req_c: cover property (tr_go && !sync_ab);
    frame_req_c: cover property (tr_go && sync_ab);
    queue_full_c: cover property (32'(dq_cnt_r) == DQ_N);
    done_c: cover property (cmpl_o);
endmodule // tdd_dma_top

// File: tb/tdd_slave_model.sv
// file: byte-wide source and destination slave model for the dma engine
`timescale 1ns/1ps
module tdd_slave_model (
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    input  wire logic        rd_req_i,
    input  wire logic [31:0] rd_addr_i,
    output logic             rd_gnt_o,
    output logic             rd_valid_o,
    output logic      [7:0]  rd_data_o,
    input  wire logic        wr_req_i,
    input  wire logic [31:0] wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    output logic             wr_gnt_o
);
    // ****************************************
    // slave behaviour
    // ****************************************
    logic [31:0] pend_q[$];
    logic [39:0] log_q[$];
    logic        tick_r;
    initial begin
        tick_r     = 1'b0;
        rd_gnt_o   = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o  = 8'h00;
        wr_gnt_o   = 1'b0;
    end
    // slow mode grants every other cycle to stall both sides
    always @(posedge clk_i) begin
        tick_r     <= ~tick_r;
        rd_gnt_o   <= ~slow_i | tick_r;
        wr_gnt_o   <= ~slow_i | ~tick_r;
        rd_valid_o <= 1'b0;
        // idle data toggles so a stale byte never passes for a fresh one
        rd_data_o  <= ~rd_data_o;
        if (rd_req_i && rd_gnt_o) begin
            pend_q.push_back(rd_addr_i);
        end
        // data only for reads already accepted
        if (pend_q.size() > 0 && (~slow_i | tick_r)) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= 8'(pend_q.pop_front()) ^ 8'h5a;
        end
        if (wr_req_i && wr_gnt_o) begin
            log_q.push_back({wr_addr_i, wr_data_i});
        end
    end
endmodule // tdd_slave_model

// File: tb/tdd_dma_top_tb.sv
// file: self-checking testbench of the dma engine top
`timescale 1ns/1ps
module tdd_dma_top_tb;
    // ****************************************
    // bench
    // ****************************************
    logic        ref_clk_i, rst_n_i, avs_read_i, avs_write_i, slow;
    logic [15:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd_addr_o, wr_addr_o, q;
    logic        avs_waitrequest_o, rd_req_o, rd_gnt_i, rd_valid_i;
    logic        wr_req_o, wr_gnt_i, cmpl_o;
    logic [7:0]  rd_data_i, wr_data_o;
    logic [5:0]  cmpl_code_o, last_code;
    int          failures, n_tests, n_cmpl;

    tdd_dma_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
        .rd_gnt_i(rd_gnt_i), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
        .wr_req_o(wr_req_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
        .wr_gnt_i(wr_gnt_i), .cmpl_o(cmpl_o), .cmpl_code_o(cmpl_code_o));
    tdd_slave_model u_slv (.clk_i(ref_clk_i), .slow_i(slow), .rd_req_i(rd_req_o),
        .rd_addr_i(rd_addr_o), .rd_gnt_o(rd_gnt_i), .rd_valid_o(rd_valid_i),
        .rd_data_o(rd_data_i), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o),
        .wr_data_i(wr_data_o), .wr_gnt_o(wr_gnt_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (cmpl_o === 1'b1) begin
            n_cmpl    <= n_cmpl + 1;
            last_code <= cmpl_code_o;
        end
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // request held until waitrequest is seen low at an edge
    // no local limit: only the watchdog ends a wait that never answers
    task automatic avs(input logic wr, input logic [15:0] a, input logic [31:0] d);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic put_set(input int n, input logic [31:0] w[8]);
        for (int k = 0; k < 8; k++) avs(1'b1, 16'(16'h4000 + n * 32 + k * 4), w[k]);
    endtask
    // trigger a channel mask, wait wt cycles or until one completion too many, then check the count
    task automatic trig(input logic [31:0] mask, input int nd, input int wt);
        int c0;
        int k;
        c0 = n_cmpl;
        k  = 0;
        avs(1'b1, 16'h0000, mask);
        while (n_cmpl - c0 < nd + 1 && k < wt) begin
            @(posedge ref_clk_i);
            k++;
        end
        chk(40'(n_cmpl - c0), 40'(nd));
    endtask
    // more: bytes of later transfers already logged behind this one
    task automatic pop(input logic [31:0] sa, da, input int ac, na, input logic [31:0] sb, db,
                       input int more = 0);
        logic [31:0] s;
        logic [31:0] d;
        chk(40'(u_slv.log_q.size()), 40'(ac * na + more));
        if (u_slv.log_q.size() == ac * na + more) begin
            for (int a = 0; a < na; a++) begin
                for (int b = 0; b < ac; b++) begin
                    s = sa + a * sb + b;
                    d = da + a * db + b;
                    chk(u_slv.log_q.pop_front(), {d, s[7:0] ^ 8'h5a});
                end
            end
        end
    endtask

    initial begin
        #2400000;
        failures++;
        close_out();
    end
    initial begin
        {rst_n_i, avs_read_i, avs_write_i, slow, failures, n_tests, n_cmpl} = '0;
        {avs_address_i, avs_writedata_i, last_code} = '0;
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        avs(1'b0, 16'h0100, 32'h0);
        chk(40'(q), 40'h0);
        avs(1'b0, 16'h3000, 32'h0);
        chk(40'(q), 40'h0);
        avs(1'b1, 16'h5ffc, 32'h0000_abcd);
        avs(1'b0, 16'h5ffc, 32'h0);
        chk(40'(q), 40'h0000_abcd);
        put_set(1, '{32'h5004, 32'h1000, 32'h2_0003, 32'h2000, 32'h4_0008, 32'h2_ffff,
                     32'h40_0020, 32'h2});
        avs(1'b0, 16'h4028, 32'h0);
        chk(40'(q), 40'h2_0003);
        avs(1'b1, 16'h0100, 32'h1);
        trig(32'h1, 1, 2000);
        chk(40'(last_code), 40'h05);
        pop(32'h1000, 32'h2000, 3, 2, 32'h8, 32'h4);
        trig(32'h1, 1, 2000);
        pop(32'h1020, 32'h2040, 3, 2, 32'h8, 32'h4);
        trig(32'h1, 0, 200);
        pop(32'h0, 32'h0, 0, 0, 32'h0, 32'h0);
        slow <= 1'b1;
        put_set(2, '{32'h9000, 32'h3000, 32'h2_0002, 32'h4000, 32'h8_0010, 32'h2_ffff,
                     32'h20_0100, 32'h2});
        avs(1'b1, 16'h0104, 32'h2);
        trig(32'h2, 1, 2000);
        chk(40'(last_code), 40'h09);
        pop(32'h3000, 32'h4000, 2, 1, 32'h0, 32'h0);
        trig(32'h2, 1, 2000);
        pop(32'h3010, 32'h4008, 2, 1, 32'h0, 32'h0);
        trig(32'h2, 1, 2000);
        pop(32'h3110, 32'h4028, 2, 1, 32'h0, 32'h0);
        trig(32'h2, 1, 2000);
        pop(32'h3120, 32'h4030, 2, 1, 32'h0, 32'h0);
        trig(32'h2, 0, 200);
        put_set(3, '{32'h3004, 32'h5000, 32'h1_0004, 32'h6000, 32'h0, 32'h1_ffff, 32'h0,
                     32'h1});
        put_set(4, '{32'h4004, 32'h5100, 32'h2_0004, 32'h6100, 32'h8_0004, 32'h2_ffff, 32'h0,
                     32'h1});
        avs(1'b1, 16'h0108, 32'h3);
        avs(1'b1, 16'h010c, 32'h4);
        trig(32'hc, 2, 4000);
        chk(40'(last_code), 40'h04);
        pop(32'h5000, 32'h6000, 4, 1, 32'h0, 32'h0, 8);
        pop(32'h5100, 32'h6100, 4, 2, 32'h4, 32'h8);
        close_out();
    end
endmodule // tdd_dma_top_tb
